// ---- verilog/spi_dac_consts.svh ----
// Shared offsets, field positions, codes and timing counts
`ifndef SPI_DAC_CONSTS_SVH
`define SPI_DAC_CONSTS_SVH
// Command word layout, bit 23 first on the wire
`define CMD_BITS        24
`define ADDR_MSB        23
`define ADDR_LSB        19
`define OP_MSB          18
`define OP_LSB          17
`define FLAG_BIT        16
// Opcodes and implemented addresses
`define OP_WRITE        2'b00
`define OP_READ         2'b11
`define ADR_DAC0        5'h00
`define ADR_DAC1        5'h01
`define ADR_VREF        5'h08
`define ADR_PDOWN       5'h09
`define ADR_GAIN        5'h0A
// Host register word indexes on the Avalon bus
`define REG_CMD         2'd0
`define REG_STATUS      2'd1
// Command register fields
`define CMD_READ_BIT    21
`define CMD_LAST_BIT    22
// Status register fields
`define ST_FLAG_BIT     16
`define ST_DONE_BIT     17
`define ST_BUSY_BIT     18
`define ST_OPEN_BIT     19
// Host serial clock half period in mclk cycles
`define SCK_HALF_CYCLES 8
`endif

// ---- verilog/spi_dac_pkg.sv ----
// Types shared by both ends of the serial DAC link
`default_nettype none
package spi_dac_pkg;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LEAD  = 3'b001,
    H_HIGH  = 3'b010,
    H_LOW   = 3'b011,
    H_CHAIN = 3'b100,
    H_GAP   = 3'b101
  } host_state_e;
endpackage : spi_dac_pkg
`default_nettype wire

// ---- verilog/spi_dac_if.sv ----
// Serial link between host controller and converter command decoder
`timescale 1ns/1ps
`default_nettype none
interface spi_dac_if;
  logic csN;               // Chip select, active low
  logic sck;               // Serial clock from host
  logic sdi;               // Host to device data
  logic sdoOut;            // Device output value
  logic sdoOe;             // Device drives the output line
  logic outputUpdateN;     // Output-update pin, driven by the bench
  logic highVoltageCmdPin; // High-voltage command pin, driven by the bench
  wire  sdoLine;
  // Shared data-out line; a pull-up holds it high while the device lets go
  assign sdoLine = sdoOe ? sdoOut : 1'b1;
  modport device (input csN, sck, sdi, outputUpdateN, highVoltageCmdPin,
                  output sdoOut, sdoOe);
  modport host (output csN, sck, sdi, input sdoLine);
endinterface : spi_dac_if
`default_nettype wire

// ---- verilog/spi_dac_host.sv ----
// Host SPI master for the converter, commanded over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "spi_dac_consts.svh"
module spi_dac_host import spi_dac_pkg::*; #(
  parameter int SCK_HALF = `SCK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Serial link
  spi_dac_if.host          link,
  // Avalon-MM slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  if (SCK_HALF < 6 || SCK_HALF > 255) begin : g_chk
    $error("SCK_HALF out of range");
  end
  host_state_e state;
  logic [7:0]  tick;
  logic [4:0]  bitCnt;
  logic [23:0] tx;
  logic [23:0] rx;
  logic        lastCmd;
  logic        sdoMeta;
  logic        sdoSync;
  logic [15:0] respData;
  logic        respFlag;
  logic        respDone;
  logic        engineFree;
  logic        accept;
  logic        launch;
  logic        tickEnd;
  assign engineFree = (state == H_IDLE) || (state == H_CHAIN);
  assign accept     = (avs_read || avs_write) && !avs_waitrequest;
  assign launch     = accept && avs_write && (avs_address == `REG_CMD);
  assign tickEnd    = (tick == 8'(SCK_HALF - 1));
  ////////////////////////////////////////////////////////////////////
  // Data-out passes two flops before the shifter reads it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdoMeta <= 1'b0;
      sdoSync <= 1'b0;
    end else begin
      sdoMeta <= link.sdoLine;
      sdoSync <= sdoMeta;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, commands held off while a word shifts
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest &&
                 (avs_read || avs_address != `REG_CMD || engineFree)) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= 32'h0000_0000;
      if (avs_read && avs_address == `REG_STATUS) begin
        avs_readdata[15:0]          <= respData;
        avs_readdata[`ST_FLAG_BIT]  <= respFlag;
        avs_readdata[`ST_DONE_BIT]  <= respDone;
        avs_readdata[`ST_BUSY_BIT]  <= !engineFree;
        avs_readdata[`ST_OPEN_BIT]  <= !link.csN;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Result of the last word. A status read clears done only if it reported it,
  // so a word that ends at the capture edge is not lost; a new set still wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      respData <= 16'h0000;
      respFlag <= 1'b0;
      respDone <= 1'b0;
    end else if (state == H_HIGH && tickEnd && bitCnt == 5'd23) begin
      respData <= {rx[14:0], sdoSync};
      respFlag <= rx[15];
      respDone <= 1'b1;
    end else if (accept && avs_read && avs_address == `REG_STATUS &&
                 avs_readdata[`ST_DONE_BIT]) begin
      respDone <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Mode 0,0 shifter: sdi changes with sck low, sdo taken at end of high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= H_IDLE;
      tick     <= 8'h00;
      bitCnt   <= 5'h00;
      tx       <= 24'h00_0000;
      rx       <= 24'h00_0000;
      lastCmd  <= 1'b1;
      link.csN <= 1'b1;
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
    end else begin
      tick <= tickEnd ? 8'h00 : tick + 8'h01;
      unique case (state)
        H_IDLE, H_CHAIN: begin
          tick <= 8'h00;
          if (launch) begin
            // Bit 16 is the spare data bit of the command byte
            tx       <= {avs_writedata[20:16],
                         avs_writedata[`CMD_READ_BIT] ? `OP_READ : `OP_WRITE,
                         1'b0, avs_writedata[15:0]};
            lastCmd  <= avs_writedata[`CMD_LAST_BIT];
            link.sdi <= avs_writedata[20];
            link.csN <= 1'b0;
            bitCnt   <= 5'h00;
            state    <= (state == H_IDLE) ? H_LEAD : H_LOW;
          end
        end
        H_LEAD, H_LOW: if (tickEnd) begin
          link.sck <= 1'b1;
          state    <= H_HIGH;
        end
        H_HIGH: if (tickEnd) begin
          link.sck <= 1'b0;
          rx       <= {rx[22:0], sdoSync};
          tx       <= {tx[22:0], 1'b0};
          link.sdi <= tx[22];
          bitCnt   <= bitCnt + 5'h01;
          if (bitCnt == 5'd23) begin
            state <= lastCmd ? H_GAP : H_CHAIN;
          end else begin
            state <= H_LOW;
          end
        end
        H_GAP: if (tickEnd) begin
          link.csN <= 1'b1;
          state    <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : spi_dac_host
`default_nettype wire

// ---- verilog/spi_dac_device.sv ----
// Command decoder of the serial converter: frames, checks and runs commands
//
// Design decisions made here: the register addresses and the strobed register write and read ports.
`timescale 1ns/1ps
`default_nettype none
`include "spi_dac_consts.svh"
module spi_dac_device import spi_dac_pkg::*; #(
  parameter int CHANNELS   = 2,
  parameter int RESOLUTION = 12
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Serial link
  spi_dac_if.device        link,
  // Register write port, one-cycle strobe
  output logic             wrStrobe,
  output logic      [4:0]  wrAddr,
  output logic      [15:0] wrData,
  // Register read port, answered combinationally
  output logic      [4:0]  rdAddr,
  input  wire logic [15:0] rdRegData,
  input  wire logic [15:0] rdOutData
);
  if (!(CHANNELS inside {1, 2}) || !(RESOLUTION inside {8, 10, 12})) begin : g_chk
    $error("Unsupported channel count or resolution");
  end
  // Bits above the resolution are forced to one when read
  localparam logic [15:0] DATA_MASK = 16'((32'd1 << RESOLUTION) - 32'd1);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:0] pinMeta;
  logic [4:0] pinSync;
  logic       csSyncN;
  logic       sckSync;
  logic       sdiSync;
  logic       updateSyncN;
  logic       hvSync;
  // Every pin is asynchronous to mclk, so two flops each
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= 5'b1_0000;
      pinSync <= 5'b1_0000;
    end else begin
      pinMeta <= {link.csN, link.sck, link.sdi, link.outputUpdateN,
                  link.highVoltageCmdPin};
      pinSync <= pinMeta;
    end
  end
  assign csSyncN     = pinSync[4];
  assign sckSync     = pinSync[3];
  assign sdiSync     = pinSync[2];
  assign updateSyncN = pinSync[1];
  assign hvSync      = pinSync[0];

  ////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised pins
  logic csPrevN;
  logic sckPrev;
  logic csFall;
  logic sckRise;
  logic sckFall;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      csPrevN <= 1'b1;
      sckPrev <= 1'b0;
    end else begin
      csPrevN <= csSyncN;
      sckPrev <= sckSync;
    end
  end
  assign csFall  = csPrevN & ~csSyncN;
  assign sckRise = sckSync & ~sckPrev;
  assign sckFall = ~sckSync & sckPrev;

  ////////////////////////////////////////////////////////////////////
  // Command byte decode
  logic        active;
  logic        idleHigh;
  logic        seenRise;
  logic [4:0]  pos;
  logic [22:0] shiftIn;
  logic        command_error_flag;
  logic        cmdRead;
  logic [6:0]  cmdByte;
  logic [23:0] fullWord;
  logic        addrOk;
  logic        opOk;
  logic        shiftRise;
  logic        shiftFall;
  assign cmdByte  = {shiftIn[5:0], sdiSync};
  assign fullWord = {shiftIn, sdiSync};
  // Dual-channel part adds the second converter register
  assign addrOk = (cmdByte[6:2] == `ADR_DAC0) || (cmdByte[6:2] == `ADR_VREF) ||
                  (cmdByte[6:2] == `ADR_PDOWN) || (cmdByte[6:2] == `ADR_GAIN) ||
                  (cmdByte[6:2] == `ADR_DAC1 && CHANNELS == 2);
  assign opOk   = (cmdByte[1:0] == `OP_WRITE) || (cmdByte[1:0] == `OP_READ);
  assign shiftRise = active && !csSyncN && sckRise;
  // In mode 1,1 the first falling edge precedes any data, so skip it
  assign shiftFall = active && !csSyncN && sckFall && (seenRise || !idleHigh);

  ////////////////////////////////////////////////////////////////////
  // Frame state: armed only by a fresh select edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      active   <= 1'b0;
      idleHigh <= 1'b0;
      seenRise <= 1'b0;
    end else if (csSyncN) begin
      active   <= 1'b0;
      seenRise <= 1'b0;
    end else if (csFall) begin
      active   <= 1'b1;
      idleHigh <= sckSync;
      seenRise <= 1'b0;
    end else if (shiftRise) begin
      seenRise <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bit counter and input shifter, wrapping every 24 bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pos     <= 5'd0;
      shiftIn <= 23'h00_0000;
    end else if (csSyncN || csFall) begin
      pos     <= 5'd0;
    end else if (shiftRise) begin
      shiftIn <= {shiftIn[21:0], sdiSync};
      pos     <= (pos == 5'd23) ? 5'd0 : pos + 5'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky error; only deselect clears it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      command_error_flag  <= 1'b0;
      cmdRead <= 1'b0;
      rdAddr  <= 5'h00;
    end else if (csSyncN) begin
      command_error_flag  <= 1'b0;
    end else if (shiftRise && pos == 5'd6) begin
      if (!(addrOk && opOk)) begin
        command_error_flag <= 1'b1;
      end
      cmdRead <= (cmdByte[1:0] == `OP_READ);
      rdAddr  <= cmdByte[6:2];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write port: fires on the 24th rising edge of a clean write command while the high-voltage pin is low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrStrobe <= 1'b0;
      wrAddr   <= 5'h00;
      wrData   <= 16'h0000;
    end else begin
      // A partial word never gets here, so the trailing partial word of an odd-length frame changes nothing
      wrStrobe <= shiftRise && pos == 5'd23 && !command_error_flag && !cmdRead &&
                  !hvSync;
      if (shiftRise && pos == 5'd23) begin
        wrAddr <= fullWord[`ADDR_MSB:`ADDR_LSB];
        wrData <= fullWord[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read word: live output value for converter registers when requested
  logic [15:0] readWord;
  logic        dacAddr;
  assign dacAddr  = (rdAddr == `ADR_DAC0) || (rdAddr == `ADR_DAC1);
  assign readWord = ((updateSyncN && dacAddr) ? rdOutData : rdRegData)
                    | ~DATA_MASK;

  ////////////////////////////////////////////////////////////////////
  // Data-out driver: changes only on falling edges while selected; deselect returns it high
  logic [15:0] shiftOut;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.sdoOut <= 1'b1;
      link.sdoOe  <= 1'b0;
      shiftOut    <= 16'h0000;
    end else if (csSyncN) begin
      link.sdoOe  <= 1'b0;
      link.sdoOut <= 1'b1;
    end else if (csFall) begin
      link.sdoOe  <= 1'b1;
      link.sdoOut <= 1'b1;
    end else if (shiftFall) begin
      if (command_error_flag && pos != 5'd7) begin
        link.sdoOut <= 1'b0;
      end else if (pos < 5'd7) begin
        link.sdoOut <= 1'b1;
      end else if (pos == 5'd7) begin
        link.sdoOut <= !command_error_flag;
      end else if (pos == 5'd8) begin
        link.sdoOut <= cmdRead ? readWord[15] : 1'b1;
        shiftOut    <= {readWord[14:0], 1'b1};
      end else begin
        link.sdoOut <= cmdRead ? shiftOut[15] : 1'b1;
        shiftOut    <= {shiftOut[14:0], 1'b1};
      end
    end
  end
endmodule : spi_dac_device
`default_nettype wire

// ---- test/spi_dac_link_props.sv ----
// Checker for the serial link between host controller and command decoder
`timescale 1ns/1ps
`default_nettype none
module spi_dac_link_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Serial link
  input wire logic csN,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe
);
  logic       sckD;
  logic       errSeen;
  logic [4:0] wordBit;
  logic       rise;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Host sck rises seen on mclk; sdo is settled by then, so sample it here
  assign rise = sck & ~sckD;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) sckD <= 1'b0;
    else sckD <= sck;
  end
  // Bit index within the current 24-bit word, cleared while deselected
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) wordBit <= 5'd0;
    else if (csN) wordBit <= 5'd0;
    else if (rise) wordBit <= (wordBit == 5'd23) ? 5'd0 : wordBit + 5'd1;
  end
  // Error seen on the flag bit; only deselect clears it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) errSeen <= 1'b0;
    else if (csN) errSeen <= 1'b0;
    else if (rise && wordBit == 5'd7 && !sdoOut) errSeen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  release_out_a: assert property (csN [*5] |-> !sdoOe)
    else $error("data out driven while deselected");
  drive_out_a: assert property ((!csN) [*5] |-> sdoOe)
    else $error("data out not driven in frame");
  cmd_high_a: assert property (rise && wordBit < 5'd7 && !errSeen |-> sdoOut)
    else $error("command bit time not high");
  err_low_a: assert property (rise && errSeen |-> !sdoOut)
    else $error("data out not low after error");
  sdi_stable_a: assert property (!csN && $changed(sdi) |-> !sck)
    else $error("sdi changed while sck high");
  sdo_stable_a: assert property (!csN && sdoOe && $changed(sdoOut) |-> !sck)
    else $error("sdo changed while sck high");
  lead_low_a: assert property ($fell(csN) |-> (!sck) [*8])
    else $error("sck not low after select");
  idle_low_a: assert property (csN |-> !sck)
    else $error("sck active while deselected");
  whole_word_a: assert property ($rose(csN) |-> wordBit == 5'd0)
    else $error("frame ended mid word");
endmodule : spi_dac_link_props
`default_nettype wire

// ---- test/spi_dac_command_decoder_tb.sv ----
// Testbench joining host controller and command decoder over the link
`timescale 1ns/1ps
`default_nettype none
`include "spi_dac_consts.svh"
module spi_dac_command_decoder_tb;
  typedef struct packed {
    logic [4:0] a; logic rd; logic [15:0] d; logic flag; logic [15:0] q; logic stb;
  } row_s;
  logic        mclk = 1'b0;
  logic        arst_n;
  logic [1:0]  avAddr;
  logic        avRd;
  logic        avWr;
  logic [31:0] avWdata;
  logic [31:0] avRdata;
  logic        avWait;
  logic        wrStrobe;
  logic [4:0]  wrAddr;
  logic [15:0] wrData;
  logic [4:0]  rdAddr;
  logic [15:0] regs [32];
  logic [31:0] st;
  int          stbCount = 0;
  int          num_errors = 0;
  int          check_count = 0;
  int          s0;
  logic [31:0] prevData;
  logic        agreed;
  row_s rows [9] = '{
    '{5'h00, 1'b0, 16'h0ABC, 1'b1, 16'hFFFF, 1'b1}, '{5'h00, 1'b1, 16'h0, 1'b1, 16'hFABC, 1'b0},
    '{5'h01, 1'b0, 16'h0123, 1'b1, 16'hFFFF, 1'b1}, '{5'h01, 1'b1, 16'h0, 1'b1, 16'hF123, 1'b0},
    '{5'h09, 1'b0, 16'h5A5A, 1'b1, 16'hFFFF, 1'b1}, '{5'h09, 1'b1, 16'h0, 1'b1, 16'hFA5A, 1'b0},
    '{5'h0A, 1'b0, 16'h0005, 1'b1, 16'hFFFF, 1'b1}, '{5'h02, 1'b1, 16'h0, 1'b0, 16'h0000, 1'b0},
    '{5'h1F, 1'b0, 16'h1234, 1'b0, 16'h0000, 1'b0}};
  spi_dac_if link ();
  ////////////////////////////////////////////////////////////////////////////
  // Clock; register storage sits outside the decoder, so the bench keeps it
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (wrStrobe === 1'b1) begin
      regs[wrAddr] <= wrData;
      stbCount <= stbCount + 1;
    end
  end
  spi_dac_host #(.SCK_HALF(8)) u_spi_dac_host (.mclk(mclk), .arst_n(arst_n), .link(link.host),
    .avs_address(avAddr), .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWdata),
    .avs_readdata(avRdata), .avs_waitrequest(avWait));
  spi_dac_device #(.CHANNELS(2), .RESOLUTION(12)) u_spi_dac_device (.mclk(mclk),
    .arst_n(arst_n), .link(link.device), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
    .rdAddr(rdAddr), .rdRegData(regs[rdAddr]), .rdOutData(regs[rdAddr] ^ 16'h0FFF));
  spi_dac_link_props u_spi_dac_link_props (.mclk(mclk), .arst_n(arst_n), .csN(link.csN),
    .sck(link.sck), .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic busOp(input logic [1:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avAddr <= a;
    avWdata <= d;
    avWr <= wr;
    avRd <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avWait !== 1'b0 && n < 1000);
    q = avRdata;
    avWr <= 1'b0;
    avRd <= 1'b0;
    if (n >= 1000) begin
      num_errors++;
      print_verdict();
    end
  endtask : busOp
  // Issue one command word and poll status until its done bit is seen
  task automatic issue(input logic [4:0] a, input logic rd, input logic last,
                       input logic [15:0] d);
    int n;
    n = 0;
    busOp(`REG_CMD, 1'b1, {9'd0, last, rd, a, d}, st);
    do begin
      busOp(`REG_STATUS, 1'b0, 32'h0000_0000, st);
      n++;
    end while (st[`ST_DONE_BIT] !== 1'b1 && n < 300);
    if (n >= 300) begin
      num_errors++;
      print_verdict();
    end
  endtask : issue
  // Issue one command word, then compare flag, data and frame state
  task automatic cmd(input logic [4:0] a, input logic rd, input logic last,
                     input logic [15:0] d, input logic flag, input logic [15:0] q);
    issue(a, rd, last, d);
    check({15'd0, st[16:0]}, {15'd0, flag, q});
    // Frame stays open after a word; engine busy only while closing it
    check({30'd0, st[`ST_OPEN_BIT:`ST_BUSY_BIT]}, {30'd0, 1'b1, last});
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    avAddr = 2'd0;
    avRd = 1'b0;
    avWr = 1'b0;
    avWdata = 32'h0000_0000;
    link.outputUpdateN = 1'b0;
    link.highVoltageCmdPin = 1'b0;
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i]) begin
      s0 = stbCount;
      cmd(rows[i].a, rows[i].rd, 1'b1, rows[i].d, rows[i].flag, rows[i].q);
      check(32'(stbCount - s0), {31'd0, rows[i].stb});
      if (rows[i].stb) check({16'd0, regs[rows[i].a]}, {16'd0, rows[i].d});
      $display("row %0d done", i);
    end
    // Error in mid frame: the following write is ignored and reads low
    s0 = stbCount;
    cmd(5'h02, 1'b1, 1'b0, 16'h0000, 1'b0, 16'h0000);
    cmd(5'h00, 1'b0, 1'b1, 16'h0777, 1'b0, 16'h0000);
    check(32'(stbCount - s0), 32'd0);
    $display("error frame done");
    // Read then two writes to different places in one frame, then a second frame reading both back
    cmd(5'h0A, 1'b1, 1'b0, 16'h0000, 1'b1, 16'hF005);
    cmd(5'h08, 1'b0, 1'b0, 16'h0111, 1'b1, 16'hFFFF);
    cmd(5'h09, 1'b0, 1'b1, 16'h0222, 1'b1, 16'hFFFF);
    cmd(5'h08, 1'b1, 1'b0, 16'h0000, 1'b1, 16'hF111);
    cmd(5'h09, 1'b1, 1'b1, 16'h0000, 1'b1, 16'hF222);
    $display("continuous frames done");
    // High-voltage level: write dropped without error, read unaffected
    link.highVoltageCmdPin <= 1'b1;
    s0 = stbCount;
    cmd(5'h08, 1'b0, 1'b1, 16'h0999, 1'b1, 16'hFFFF);
    check(32'(stbCount - s0), 32'd0);
    cmd(5'h08, 1'b1, 1'b1, 16'h0000, 1'b1, 16'hF111);
    link.highVoltageCmdPin <= 1'b0;
    // Update pin high: converter read returns the live output value
    link.outputUpdateN <= 1'b1;
    cmd(5'h00, 1'b1, 1'b1, 16'h0000, 1'b1, {4'hF, 12'hABC ^ 12'hFFF});
    // Update pin falls between reads: repeat until two results agree
    fork
      begin
        repeat (200) @(posedge mclk);
        link.outputUpdateN <= 1'b0;
      end
    join_none
    prevData = 32'hFFFF_FFFF;
    agreed = 1'b0;
    for (int k = 0; k < 4 && !agreed; k++) begin
      issue(5'h00, 1'b1, 1'b1, 16'h0000);
      agreed = (st[16:0] === prevData[16:0]);
      prevData = st;
    end
    check({31'd0, agreed}, 32'd1);
    check({15'd0, st[16:0]}, {15'd0, 1'b1, 16'hFABC});
    $display("pin tests done");
    // Second reset in mid run, then a normal read
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    check({28'd0, link.csN, link.sck, link.sdoOe, avWait}, 32'h0000_0009);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cmd(5'h00, 1'b1, 1'b1, 16'h0000, 1'b1, 16'hFABC);
    $display("reset test done");
    print_verdict();
  end
endmodule : spi_dac_command_decoder_tb
`default_nettype wire
